// *** hw/kbc_ctrl.sv ***
// Keyboard serial controller: link engine, clock crossings, output buffer and send path.
`timescale 1ns/1ns
`default_nettype none
`include "kbc_regs.svh"

// Summary of operation
// R1: Every byte received from the keyboard has its parity checked and a bad byte is not passed on.
// R2: Each good received scan code is translated and placed in the output buffer for the system.
// R3: A byte placed in the output buffer can raise the interrupt request to the processor.
// R4: A status flag shows software by polling that a byte waits in the output buffer.
// R5: A byte written by the system is sent to the keyboard over the serial link.
// R6: Every byte sent on the link is followed by an odd parity bit made automatically.
// R7: The receiving end of every byte transfer returns an acknowledgment.
// R8: A sender holds back its next byte until the previous byte has been acknowledged; the send path takes the next byte after the ack slot, acked or not.
// R9: The same interrupt serves both the receive path and the send path.
// R10: A frame is a start bit, eight data bits LSB first, parity and stop, clocked by the keyboard.
module kbc_ctrl
	import kbc_pkg::*;
(
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic       KB_CLK,
	input  wire logic       KB_DATA_I,
	output var  logic       KB_DATA_O,
	output var  logic       KB_DATA_OE,
	output var  logic       KB_CLK_O,
	output var  logic       KB_CLK_OE,
	input  wire logic       WR_VALID,
	input  wire logic [7:0] WR_DATA,
	output var  logic       WR_READY,
	output var  logic       OUT_VALID,
	output var  logic [7:0] OUT_DATA,
	input  wire logic       OUT_READY,
	input  wire logic       IRQ_EN,
	input  wire logic       XLATE_EN,
	output var  logic       IRQ,
	output var  logic       PAR_ERR,
	output var  logic       TX_ERR
);

	// ****************************************
	// Declarations
	// ****************************************
	kbc_lst_t   l_st;
	logic [3:0] l_cnt;
	logic [7:0] l_sh;
	logic       l_par;
	logic [7:0] l_txw;
	logic [7:0] l_rx_word;
	logic       l_rx_ok;
	logic       l_rx_tgl;
	logic       l_done_tgl;
	logic       l_ack_ok;
	logic [2:0] l_req_sync;
	logic       l_req_seen;
	logic       l_go;
	logic [2:0] rx_sync;
	logic       rx_seen;
	logic       rx_evt;
	logic [2:0] dn_sync;
	logic       dn_seen;
	logic       done_evt;
	logic       tx_req;
	logic [7:0] tx_word;
	logic       accept;
	logic       brk;
	logic       is_pfx;
	logic       push;
	logic [7:0] push_data;
	logic       pop;
	logic [7:0] m1;
	logic       v1;
	logic       s_v0;
	logic       s_v1;
	logic [7:0] s_m0;
	logic       next_v0;
	logic       next_v1;
	logic [7:0] next_m0;
	logic [7:0] next_m1;

	// ****************************************
	// Link domain, clocked by the keyboard
	// ****************************************

	// Send request toggle passes three flops; only the agreeing pair is used.
	always_ff @(posedge KB_CLK or posedge RST) begin
		if (RST) l_req_sync <= 3'h0;
		else     l_req_sync <= {l_req_sync[1:0], tx_req};
	end

	assign l_go = (l_req_sync[2] == l_req_sync[1]) && (l_req_sync[2] != l_req_seen);

	// Frame engine. A frame from the keyboard has priority over a pending send,
	// because the keyboard owns the clock and has already begun.
	always_ff @(posedge KB_CLK or posedge RST) begin
		if (RST) begin
			l_st       <= L_IDLE;
			l_cnt      <= 4'h0;
			l_sh       <= 8'h00;
			l_par      <= 1'b0;
			l_txw      <= 8'h00;
			l_rx_word  <= 8'h00;
			l_rx_ok    <= 1'b0;
			l_rx_tgl   <= 1'b0;
			l_done_tgl <= 1'b0;
			l_ack_ok   <= 1'b0;
			l_req_seen <= 1'b0;
			KB_DATA_OE <= 1'b0;
		end else begin
			case (l_st)
				L_IDLE: begin
					if (!KB_DATA_I) begin
						l_st  <= L_RX; // R10
						l_cnt <= `KBC_CNT_FIRST;
					end else if (l_go) begin
						l_st       <= L_TX; // R5
						l_cnt      <= `KBC_CNT_FIRST;
						l_txw      <= tx_word;
						l_req_seen <= l_req_sync[2];
						KB_DATA_OE <= 1'b1; // R10
					end
				end
				L_RX: begin
					l_cnt <= l_cnt + 4'd1;
					if (l_cnt <= `KBC_BIT_LAST_DATA) l_sh <= {KB_DATA_I, l_sh[7:1]}; // R10
					if (l_cnt == `KBC_BIT_PAR) l_par <= KB_DATA_I;
					if (l_cnt == `KBC_BIT_STOP) begin
						l_rx_word  <= l_sh;
						l_rx_ok    <= (^{l_sh, l_par}) && KB_DATA_I; // R1
						KB_DATA_OE <= 1'b1; // R7
					end
					// The byte is announced only after the ack slot, so the clock inhibit
					// that follows a stored byte can never swallow the frame's last edge.
					if (l_cnt == `KBC_BIT_ACK) begin
						l_rx_tgl   <= ~l_rx_tgl;
						KB_DATA_OE <= 1'b0;
						l_st       <= L_IDLE;
					end
				end
				L_TX: begin
					l_cnt <= l_cnt + 4'd1;
					if (l_cnt <= `KBC_BIT_LAST_DATA) KB_DATA_OE <= ~l_txw[l_cnt[2:0] - 3'd1]; // R10
					if (l_cnt == `KBC_BIT_PAR) KB_DATA_OE <= ^l_txw; // R6
					if (l_cnt == `KBC_BIT_STOP) KB_DATA_OE <= 1'b0;
					if (l_cnt == `KBC_BIT_ACK) begin
						l_ack_ok   <= !KB_DATA_I; // R7
						l_done_tgl <= ~l_done_tgl; // R8
						l_st       <= L_IDLE;
					end
				end
				default: l_st <= L_IDLE;
			endcase
		end
	end

	// The data pin is open drain: it is only ever pulled low.
	always_ff @(posedge KB_CLK or posedge RST) begin
		if (RST) KB_DATA_O <= 1'b0;
		else     KB_DATA_O <= 1'b0;
	end

	// ****************************************
	// System domain: crossings
	// ****************************************

	// Event toggles from the link pass three flops each.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rx_sync <= 3'h0;
			dn_sync <= 3'h0;
			rx_seen <= 1'b0;
			dn_seen <= 1'b0;
		end else begin
			rx_sync <= {rx_sync[1:0], l_rx_tgl};
			dn_sync <= {dn_sync[1:0], l_done_tgl};
			if (rx_evt) rx_seen <= rx_sync[2];
			if (done_evt) dn_seen <= dn_sync[2];
		end
	end

	// The link holds word and flags stable for a whole frame after each toggle.
	assign rx_evt   = (rx_sync[2] == rx_sync[1]) && (rx_sync[2] != rx_seen);
	assign done_evt = (dn_sync[2] == dn_sync[1]) && (dn_sync[2] != dn_seen);

	// ****************************************
	// Receive path and two-entry output buffer
	// ****************************************
	assign is_pfx    = XLATE_EN && (l_rx_word == `KBC_BRK_PFX);
	assign push      = rx_evt && l_rx_ok && !is_pfx && !v1; // R1
	assign push_data = XLATE_EN ? (kbc_xlate(l_rx_word) | (brk ? `KBC_BRK_FLAG : 8'h00)) : l_rx_word; // R2
	assign pop       = OUT_READY && OUT_VALID;

	// Head entry drives the ports directly; the second entry absorbs the byte in flight.
	assign s_v0    = pop ? v1 : OUT_VALID;
	assign s_v1    = pop ? 1'b0 : v1;
	assign s_m0    = pop ? m1 : OUT_DATA;
	assign next_v0 = s_v0 | push; // R4
	assign next_m0 = (push && !s_v0) ? push_data : s_m0; // R2
	assign next_v1 = s_v1 | (push && s_v0);
	assign next_m1 = (push && s_v0) ? push_data : m1;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			OUT_VALID <= 1'b0;
			OUT_DATA  <= 8'h00;
			v1        <= 1'b0;
			m1        <= 8'h00;
		end else begin
			OUT_VALID <= next_v0;
			OUT_DATA  <= next_m0;
			v1        <= next_v1;
			m1        <= next_m1;
		end
	end

	// A break prefix is folded into the following code instead of being stored.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST)                           brk <= 1'b0;
		else if (rx_evt && l_rx_ok && is_pfx) brk <= 1'b1;
		else if (push)                     brk <= 1'b0;
	end

	// Holding the keyboard clock low while a byte waits is the back-pressure:
	// the keyboard defers its next frame, so the spare entry never overflows.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			KB_CLK_OE <= 1'b0;
			KB_CLK_O  <= 1'b0;
		end else begin
			KB_CLK_OE <= next_v0;
			KB_CLK_O  <= 1'b0;
		end
	end

	// Interrupt on a waiting byte or a finished send; error pulses.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			IRQ     <= 1'b0;
			PAR_ERR <= 1'b0;
			TX_ERR  <= 1'b0;
		end else begin
			IRQ     <= IRQ_EN && (next_v0 || done_evt); // R3 R9
			PAR_ERR <= rx_evt && !l_rx_ok; // R1
			TX_ERR  <= done_evt && !l_ack_ok; // R7
		end
	end

	// ****************************************
	// Send path
	// ****************************************
	assign accept = WR_VALID && WR_READY;

	// The word stays put until the acknowledgment returns, which is what lets
	// the link read it across the clock boundary without its own crossing.
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			tx_req   <= 1'b0;
			tx_word  <= 8'h00;
			WR_READY <= 1'b1;
		end else if (accept) begin
			tx_req   <= ~tx_req; // R5
			tx_word  <= WR_DATA;
			WR_READY <= 1'b0; // R8
		end else if (done_evt) begin
			WR_READY <= 1'b1; // R8
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_par_drop;
		@(posedge CLK) disable iff (RST) rx_evt && !l_rx_ok |-> !push ##1 PAR_ERR;
	endproperty
	a_par_drop: assert property (p_par_drop) else $error("bad parity byte was stored"); // R1

	property p_xlate;
		@(posedge CLK) disable iff (RST) push && XLATE_EN && !brk && !s_v0 |=> OUT_DATA == kbc_xlate($past(l_rx_word));
	endproperty
	a_xlate: assert property (p_xlate) else $error("received code not translated"); // R2

	property p_irq;
		@(posedge CLK) disable iff (RST) IRQ_EN && push |=> IRQ && OUT_VALID;
	endproperty
	a_irq: assert property (p_irq) else $error("no interrupt for stored byte"); // R3

	property p_status;
		@(posedge CLK) disable iff (RST) OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA);
	endproperty
	a_status: assert property (p_status) else $error("waiting byte lost from buffer"); // R4

	property p_send;
		@(posedge CLK) disable iff (RST) accept |=> tx_req != $past(tx_req) && tx_word == $past(WR_DATA);
	endproperty
	a_send: assert property (p_send) else $error("written byte not sent"); // R5

	property p_parity;
		@(posedge KB_CLK) disable iff (RST) l_st == L_TX && l_cnt == `KBC_BIT_PAR |=> KB_DATA_OE == ^l_txw;
	endproperty
	a_parity: assert property (p_parity) else $error("sent parity not odd"); // R6

	property p_ack;
		@(posedge KB_CLK) disable iff (RST) l_st == L_RX && l_cnt == `KBC_BIT_STOP |=> KB_DATA_OE ##1 !KB_DATA_OE;
	endproperty
	a_ack: assert property (p_ack) else $error("received byte not acknowledged"); // R7

	property p_hold;
		@(posedge CLK) disable iff (RST) accept |=> !WR_READY [*8];
	endproperty
	a_hold: assert property (p_hold) else $error("next byte taken before acknowledgment"); // R8

	property p_tx_irq;
		@(posedge CLK) disable iff (RST) done_evt && IRQ_EN |=> IRQ && WR_READY;
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("no interrupt after send"); // R9

	property p_start;
		@(posedge KB_CLK) disable iff (RST) l_st == L_IDLE && KB_DATA_I && l_go |=> KB_DATA_OE && l_st == L_TX;
	endproperty
	a_start: assert property (p_start) else $error("send frame lacks start bit"); // R10

	c_rx:   cover property (@(posedge CLK) disable iff (RST) push);
	c_brk:  cover property (@(posedge CLK) disable iff (RST) push && brk);
	c_full: cover property (@(posedge CLK) disable iff (RST) v1);
	c_tx:   cover property (@(posedge CLK) disable iff (RST) done_evt && l_ack_ok);

endmodule : kbc_ctrl
`default_nettype wire

// *** pkg/kbc_regs.svh ***
// Constants for the keyboard serial controller: frame slots and break codes.
`ifndef KBC_REGS_SVH
`define KBC_REGS_SVH
`define KBC_BIT_LAST_DATA 4'd8
`define KBC_BIT_PAR       4'd9
`define KBC_BIT_STOP      4'd10
`define KBC_BIT_ACK       4'd11
`define KBC_CNT_FIRST     4'd1
`define KBC_BRK_PFX       8'hf0
`define KBC_BRK_FLAG      8'h80
`endif

// *** pkg/kbc_pkg.sv ***
// Types and the scan-code translation table of the keyboard serial controller.
`default_nettype none
package kbc_pkg;

	// Link-side states, Gray coded along idle-receive and idle-send.
	typedef enum logic [1:0] {
		L_IDLE = 2'b00,
		L_RX   = 2'b01,
		L_TX   = 2'b10
	} kbc_lst_t;

	// Maps keyboard codes to system codes; unlisted codes pass unchanged.
	function automatic logic [7:0] kbc_xlate(input logic [7:0] c);
		logic [7:0] r;
		r = c;
		case (c)
			8'h76: r = 8'h01;
			8'h16: r = 8'h02;
			8'h1e: r = 8'h03;
			8'h26: r = 8'h04;
			8'h25: r = 8'h05;
			8'h0d: r = 8'h0f;
			8'h1c: r = 8'h1e;
			8'h5a: r = 8'h1c;
			8'h66: r = 8'h0e;
			8'h29: r = 8'h39;
			default: r = c;
		endcase
		return r;
	endfunction : kbc_xlate

endpackage : kbc_pkg
`default_nettype wire

// *** tb/kbc_kbd_model.sv ***
// Behavioural keyboard at the far end of the two-wire link.
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Keyboard model
// ****************************************
module kbc_kbd_model (
	output var  logic kclk,
	output var  logic drv_low,
	input  wire logic data_wire,
	input  wire logic inhibit
);
	// Clock stays low and data stays released until a task runs a frame.
	initial begin
		kclk = 1'b0;
		drv_low = 1'b0;
	end

	// One link period; keyboard data moves in the low phase and is sampled on the rise, controller data moves on the rise.
	task automatic pulse;
		#63;
		kclk = 1'b1;
		#62;
		kclk = 1'b0;
	endtask : pulse

	task automatic idle(input int n);
		repeat (n) pulse();
	endtask : idle

	// Sends a frame; bad_par flips parity, acked tells whether the ack slot was low.
	task automatic send_byte(input logic [7:0] b, input logic bad_par, output logic acked);
		logic [10:0] fr;
		int          n;
		fr = {1'b1, ~^b ^ bad_par, b, 1'b0};
		n = 0;
		// A keyboard holds its frame while the controller inhibits the clock.
		while (inhibit === 1'b1 && n < 400) begin
			#125;
			n++;
		end
		for (int i = 0; i < 11; i++) begin
			drv_low = ~fr[i];
			pulse();
		end
		acked = (data_wire === 1'b0);
		pulse();
	endtask : send_byte

	// Clocks idle until the start bit shows, then takes the frame and answers the ack slot.
	task automatic recv_byte(input logic give_ack, output logic [7:0] b, output logic par_ok);
		logic [10:0] fr;
		int          n;
		fr = '0;
		n = 0;
		do begin
			pulse();
			n++;
		end while (data_wire !== 1'b0 && n < 16);
		for (int i = 1; i < 11; i++) begin
			pulse();
			fr[i] = data_wire;
		end
		par_ok = (^fr[9:1] === 1'b1) && (fr[10] === 1'b1);
		drv_low = give_ack;
		pulse();
		drv_low = 1'b0;
		b = fr[8:1];
	endtask : recv_byte
endmodule : kbc_kbd_model
`default_nettype wire

// *** tb/tb_keyboard_serial_controller.sv ***
// Self-checking bench for the keyboard serial controller.
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Bench top
// ****************************************
module tb_keyboard_serial_controller;
	logic            CLK, RST, WR_VALID, OUT_READY, IRQ_EN, XLATE_EN, kclk, drv_low, ok, ack;
	logic [7:0]      WR_DATA, b;
	wire logic       KB_DATA_O, KB_DATA_OE, KB_CLK_O, KB_CLK_OE, WR_READY, OUT_VALID, IRQ, PAR_ERR, TX_ERR;
	wire logic [7:0] OUT_DATA;
	int              miscompares, check_count, n_par, n_txe, n_irq;
	// Open-drain wires: a party pulling low wins, else the pull-up holds them high.
	wire logic       clk_inh = KB_CLK_OE & ~KB_CLK_O;
	wire logic       data_w  = ~(drv_low | (KB_DATA_OE & ~KB_DATA_O));
	wire logic       clk_w   = kclk & ~clk_inh;

	kbc_ctrl i_kbc_ctrl (.CLK(CLK), .RST(RST), .KB_CLK(clk_w), .KB_DATA_I(data_w), .KB_DATA_O(KB_DATA_O),
		.KB_DATA_OE(KB_DATA_OE), .KB_CLK_O(KB_CLK_O), .KB_CLK_OE(KB_CLK_OE), .WR_VALID(WR_VALID),
		.WR_DATA(WR_DATA), .WR_READY(WR_READY), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA),
		.OUT_READY(OUT_READY), .IRQ_EN(IRQ_EN), .XLATE_EN(XLATE_EN), .IRQ(IRQ), .PAR_ERR(PAR_ERR),
		.TX_ERR(TX_ERR));
	kbc_kbd_model i_kbc_kbd_model (.kclk(kclk), .drv_low(drv_low), .data_wire(data_w), .inhibit(clk_inh));

	// System clock, 8 ns period.
	initial begin
		CLK = 1'b0;
		forever #4 CLK = ~CLK;
	end

	// Pulse outputs are counted per cycle, so a stretched pulse shows as a wrong count.
	always @(posedge CLK) begin
		if (PAR_ERR === 1'b1) n_par++;
		if (TX_ERR === 1'b1) n_txe++;
		if (IRQ === 1'b1) n_irq++;
	end

	task automatic check(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %0t: seen %h expected %h", $time, s, e);
		end
	endtask : check

	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : complete_run

	task automatic pop;
		@(negedge CLK) OUT_READY = 1'b1;
		@(negedge CLK) OUT_READY = 1'b0;
		@(negedge CLK);
		check(8'(OUT_VALID), 8'h00);
	endtask : pop

	task automatic wr_wait(input logic l);
		int k;
		k = 0;
		do begin
			@(negedge CLK);
			k++;
		end while (WR_READY !== l && k < 1000);
	endtask : wr_wait

	// Keyboard sends one byte; v and d give the expected buffer result, which is then popped.
	task automatic rxe(input logic [7:0] c, input logic bad, input logic v, input logic [7:0] d);
		i_kbc_kbd_model.send_byte(c, bad, ack);
		repeat (8) @(negedge CLK);
		check(8'(ack), 8'h01);
		check(8'(OUT_VALID), 8'(v));
		if (v) begin
			check(OUT_DATA, d);
			check(8'(IRQ), 8'(IRQ_EN));
			check(8'(KB_CLK_OE), 8'h01);
			pop();
		end
	endtask : rxe

	task automatic t_rx;
		@(negedge CLK) XLATE_EN = 1'b1;
		IRQ_EN = 1'b1;
		rxe(8'h1c, 1'b0, 1'b1, 8'h1e);
		rxe(8'hf0, 1'b0, 1'b0, 8'h00);
		rxe(8'h1c, 1'b0, 1'b1, 8'h9e);
		@(negedge CLK) XLATE_EN = 1'b0;
		rxe(8'h1c, 1'b0, 1'b1, 8'h1c);
		$display("test rx done");
	endtask : t_rx

	task automatic t_par;
		int p, q;
		p = n_par;
		q = n_irq;
		@(negedge CLK) IRQ_EN = 1'b0;
		XLATE_EN = 1'b1;
		rxe(8'h5a, 1'b1, 1'b0, 8'h00);
		check(8'(n_par - p), 8'h01);
		rxe(8'h5a, 1'b0, 1'b1, 8'h1c);
		check(8'(n_irq - q), 8'h00);
		$display("test parity done");
	endtask : t_par

	// The buffer holds its byte and inhibits the link; the next frame waits for the pop.
	task automatic t_buf;
		i_kbc_kbd_model.send_byte(8'h26, 1'b0, ack);
		fork
			i_kbc_kbd_model.send_byte(8'h16, 1'b0, ack);
			begin
				repeat (60) @(negedge CLK);
				check(8'(OUT_VALID), 8'h01);
				check(OUT_DATA, 8'h04);
				check(8'(KB_CLK_OE), 8'h01);
				pop();
			end
		join
		repeat (8) @(negedge CLK);
		check(OUT_DATA, 8'h02);
		pop();
		$display("test buffer done");
	endtask : t_buf

	// Second byte is offered at once and must wait for the first acknowledgment.
	task automatic t_tx;
		int q, e;
		q = n_irq;
		e = n_txe;
		@(negedge CLK) IRQ_EN = 1'b1;
		WR_DATA = 8'ha5;
		WR_VALID = 1'b1;
		fork
			begin
				i_kbc_kbd_model.recv_byte(1'b1, b, ok);
				check(b, 8'ha5);
				check(8'(ok), 8'h01);
				i_kbc_kbd_model.recv_byte(1'b1, b, ok);
				check(b, 8'h3c);
				check(8'(ok), 8'h01);
			end
			begin
				wr_wait(1'b0);
				WR_DATA = 8'h3c;
				wr_wait(1'b1);
				@(negedge CLK) WR_VALID = 1'b0;
			end
		join
		repeat (8) @(negedge CLK);
		check(8'(WR_READY), 8'h01);
		check(8'(n_irq - q), 8'h02);
		check(8'(n_txe - e), 8'h00);
		e = n_txe;
		@(negedge CLK) WR_DATA = 8'h81;
		WR_VALID = 1'b1;
		fork
			i_kbc_kbd_model.recv_byte(1'b0, b, ok);
			begin
				wr_wait(1'b0);
				WR_VALID = 1'b0;
			end
		join
		repeat (8) @(negedge CLK);
		check(b, 8'h81);
		check(8'(n_txe - e), 8'h01);
		check(8'(WR_READY), 8'h01);
		$display("test send done");
	endtask : t_tx

	// Main sequence: reset, then each scenario in turn.
	initial begin
		{RST, WR_VALID, OUT_READY, IRQ_EN, XLATE_EN, WR_DATA} = {5'h10, 8'h00};
		{miscompares, check_count, n_par, n_txe, n_irq} = '0;
		repeat (12) @(posedge CLK);
		@(negedge CLK) RST = 1'b0;
		check(8'(WR_READY), 8'h01);
		check(8'(OUT_VALID), 8'h00);
		t_rx();
		t_par();
		t_buf();
		t_tx();
		complete_run();
	end

	// Watchdog well beyond the expected run of about 20 us.
	initial begin
		#400000;
		miscompares++;
		$display("ERROR %0t: timeout", $time);
		complete_run();
	end
endmodule : tb_keyboard_serial_controller
`default_nettype wire
